// file: logic/orc_pkg.sv
// Shared constants for the over-range and clock-out select block.
// Assumes a single 50 MHz clock and a 32-bit AHB-Lite register port.
package orc_pkg;
  // Byte offsets of the register words
  localparam logic [7:0] ORC_CONFIG_OFS = 8'h00;
  localparam logic [7:0] ORC_STATUS_OFS = 8'h04;
  localparam logic [7:0] ORC_IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] ORC_IRQ_CLEAR_OFS = 8'h0C;
  localparam logic [7:0] ORC_IRQ_ENABLE_OFS = 8'h10;
  // Config word field positions
  localparam int ORC_THR_LSB = 0;
  localparam int ORC_THR_W = 12;
  localparam int ORC_LEN_LSB = 12;
  localparam int ORC_LEN_W = 8;
  localparam int ORC_OVR_EN_BIT = 20;
  localparam int ORC_OVR_CFG_LSB = 21;
  localparam int ORC_CLK_DIS_BIT = 23;
  localparam int ORC_D_CLK_EN_BIT = 24;
  // Config reset value: threshold at full scale, one-cycle minimum pulse
  localparam logic [31:0] ORC_CONFIG_RST = 32'h00001FFF;
  // Interrupt word layout: four over-range rises, then power-down entry
  localparam int ORC_IRQ_W = 5;
  localparam int ORC_IRQ_PD_BIT = 4;
  // Clock output selection codes of the two-bit configuration
  typedef enum logic [1:0] {
    ORC_SEL_FLAG = 2'b00,
    ORC_SEL_REF = 2'b01,
    ORC_SEL_DIV2 = 2'b10,
    ORC_SEL_DIV4 = 2'b11
  } orc_clk_sel_t;
  // AHB transfer types
  localparam logic [1:0] ORC_HTRANS_NONSEQ = 2'b10;
endpackage

// file: logic/orc_overrange_det.sv
// One channel of over-range detection with a minimum pulse length.
// Assumes samples arrive as signed words on the same clock.
`timescale 1ns/1ps
module orc_overrange_det #(
  parameter int DATA_W = 12,
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sample and settings
  input wire logic signed [DATA_W-1:0] sample,
  input wire logic [DATA_W-1:0] overrange_threshold,
  input wire logic [LEN_W-1:0] overrange_min_pulse_len,
  // Flag
  output logic flag
);
  logic [DATA_W:0] magnitude;
  logic [DATA_W:0] sample_ext;
  logic over;
  logic [LEN_W-1:0] count;
  logic [LEN_W-1:0] next_count;
  logic next_flag;
  logic [LEN_W:0] age;

  // Magnitude is one bit wider so the most negative code does not wrap
  always_comb begin
    // Negate after sign extension so the most negative code gives its true size
    sample_ext = {sample[DATA_W-1], sample};
    magnitude = sample[DATA_W-1] ? ~sample_ext + (DATA_W+1)'(1) : sample_ext;
    over = magnitude > {1'b0, overrange_threshold};
    next_flag = flag;
    next_count = count;
    if (over) begin
      next_flag = 1'b1;
      next_count = overrange_min_pulse_len;
    end else if (count > LEN_W'(1)) begin
      next_count = count - LEN_W'(1);
    end else begin
      next_count = '0;
      next_flag = 1'b0;
    end
  end

  // Registered once per cycle so the pin never glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0;
      count <= '0;
    end else begin
      flag <= next_flag;
      count <= next_count;
    end
  end

  // Age of the current pulse, read only by the checks below
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) age <= '0;
    else if (!flag) age <= '0;
    else if (age != '1) age <= age + (LEN_W+1)'(1);
  end

  over_sets_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    over |=> flag) else $error("flag not raised after over-range");
  // Summed as int so a saturated age on a long pulse cannot wrap to zero
  min_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flag) |-> int'($past(age)) + 1 >= int'($past(overrange_min_pulse_len)))
    else $error("flag dropped before minimum length");
endmodule

// file: logic/orc_ref_div.sv
// Reference clock copy and its divide-by-2 and divide-by-4 versions.
// All three are toggling flops on the single system clock.
`timescale 1ns/1ps
module orc_ref_div (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Clocks out
  output logic ref_clk,
  output logic ref_div2,
  output logic ref_div4
);
  logic [2:0] phase;
  logic [2:0] next_phase;

  // A three-bit counter: each higher bit halves the rate
  always_comb begin
    next_phase = phase + 3'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phase <= 3'h0;
    else phase <= next_phase;
  end

  assign ref_clk = phase[0];
  assign ref_div2 = phase[1];
  assign ref_div4 = phase[2];
endmodule

// file: logic/orc_top.sv
// Over-range status pins with clock-out select on channels C and D.
// Assumes AHB-Lite as the only master, samples on hclk, and
// configuration, enable and power-down pins from outside the clock domain.
`timescale 1ns/1ps
// Operation
// - Each channel flag rises when its sample magnitude exceeds the threshold.
// - A raised flag stays high at least the programmed minimum pulse length.
// - Channel B flag works only in four- and two-channel builds.
// - Channel C and D over-range detection exists only in the four-channel build.
// - Channel C pin carries a clock when pins or override select one and synth enabled.
// - With config zero or clock disabled, channel C pin shows its over-range flag.
// - Code 1 selects reference, 2 reference halved, 3 reference quartered.
// - Pin-selected clock appears from reset with no register access needed.
// - Channel D pin carries a clock only while channel C does.
// - Power-down stops the reference output and both pin clocks.
module orc_top
  import orc_pkg::*;
#(
  parameter int NUM_CHANNELS = 4,
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Samples, one per channel
  input wire logic signed [DATA_W-1:0] sample_a,
  input wire logic signed [DATA_W-1:0] sample_b,
  input wire logic signed [DATA_W-1:0] sample_c,
  input wire logic signed [DATA_W-1:0] sample_d,
  // Configuration pins
  input wire logic [1:0] clock_out_config,
  input wire logic synth_enable,
  input wire logic powerdown_input,
  // Status and clock pins
  output logic overrange_flag_a,
  output logic overrange_flag_b,
  output logic overrange_flag_c_or_clock,
  output logic overrange_flag_d_or_clock,
  output logic synth_ref_out,
  output logic irq
);
  import orc_pkg::*;

  // Elaboration checks: only one-, two- and four-channel builds exist
  if (NUM_CHANNELS != 1 && NUM_CHANNELS != 2 && NUM_CHANNELS != 4) begin : g_bad_channels
    $error("NUM_CHANNELS must be 1, 2 or 4");
  end
  if (DATA_W != ORC_THR_W) begin : g_bad_width
    $error("DATA_W must match the threshold field width");
  end

  // Pin synchronisers: first stage is read only by the second
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {powerdown_input, synth_enable, clock_out_config};
      pin_sync <= pin_meta;
    end
  end
  logic [1:0] cfg_pins;
  logic synth_en_s;
  logic pd_s;
  assign cfg_pins = pin_sync[1:0];
  assign synth_en_s = pin_sync[2];
  assign pd_s = pin_sync[3];

  // Software-visible state
  logic [31:0] config_reg;
  logic [ORC_IRQ_W-1:0] irq_status;
  logic [ORC_IRQ_W-1:0] irq_enable;
  logic [31:0] status_word;

  logic [ORC_THR_W-1:0] thr;
  logic [ORC_LEN_W-1:0] min_len;
  assign thr = config_reg[ORC_THR_LSB +: ORC_THR_W];
  assign min_len = config_reg[ORC_LEN_LSB +: ORC_LEN_W];

  // Per-channel detectors; unused channels are pruned by the variant
  logic [3:0] det_flag;
  orc_overrange_det #(.DATA_W(DATA_W), .LEN_W(ORC_LEN_W)) u_det_a (
    .hclk(hclk), .hresetn(hresetn), .sample(sample_a),
    .overrange_threshold(thr), .overrange_min_pulse_len(min_len), .flag(det_flag[0]));
  orc_overrange_det #(.DATA_W(DATA_W), .LEN_W(ORC_LEN_W)) u_det_b (
    .hclk(hclk), .hresetn(hresetn), .sample(sample_b),
    .overrange_threshold(thr), .overrange_min_pulse_len(min_len), .flag(det_flag[1]));
  orc_overrange_det #(.DATA_W(DATA_W), .LEN_W(ORC_LEN_W)) u_det_c (
    .hclk(hclk), .hresetn(hresetn), .sample(sample_c),
    .overrange_threshold(thr), .overrange_min_pulse_len(min_len), .flag(det_flag[2]));
  orc_overrange_det #(.DATA_W(DATA_W), .LEN_W(ORC_LEN_W)) u_det_d (
    .hclk(hclk), .hresetn(hresetn), .sample(sample_d),
    .overrange_threshold(thr), .overrange_min_pulse_len(min_len), .flag(det_flag[3]));

  // Variant masking of the detector outputs
  logic [3:0] flag_v;
  always_comb begin
    flag_v[0] = det_flag[0];
    flag_v[1] = (NUM_CHANNELS >= 2) && det_flag[1];
    flag_v[2] = (NUM_CHANNELS == 4) && det_flag[2];
    flag_v[3] = (NUM_CHANNELS == 4) && det_flag[3];
  end

  // Reference and divided clocks
  logic ref_clk;
  logic ref_div2;
  logic ref_div4;
  orc_ref_div u_div (
    .hclk(hclk), .hresetn(hresetn),
    .ref_clk(ref_clk), .ref_div2(ref_div2), .ref_div4(ref_div4));

  // Clock selection: the register override wins over the pins
  orc_clk_sel_t eff_sel;
  logic c_clk_on;
  logic d_clk_on;
  logic sel_clk;
  always_comb begin
    eff_sel = orc_clk_sel_t'(config_reg[ORC_OVR_EN_BIT] ?
      config_reg[ORC_OVR_CFG_LSB +: 2] : cfg_pins);
    c_clk_on = (eff_sel != ORC_SEL_FLAG) && !config_reg[ORC_CLK_DIS_BIT]
      && synth_en_s && !pd_s;
    d_clk_on = c_clk_on && config_reg[ORC_D_CLK_EN_BIT];
    case (eff_sel)
      ORC_SEL_REF: sel_clk = ref_clk;
      ORC_SEL_DIV2: sel_clk = ref_div2;
      ORC_SEL_DIV4: sel_clk = ref_div4;
      default: sel_clk = 1'b0;
    endcase
  end

  // Pin values; registered so every pin comes from a flop
  logic [5:0] next_pins;
  always_comb begin
    next_pins[0] = flag_v[0];
    next_pins[1] = flag_v[1];
    next_pins[2] = c_clk_on ? sel_clk : flag_v[2];
    next_pins[3] = d_clk_on ? sel_clk : flag_v[3];
    next_pins[4] = synth_en_s && !pd_s && ref_clk;
    next_pins[5] = |(irq_status & irq_enable);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrange_flag_a <= 1'b0;
      overrange_flag_b <= 1'b0;
      overrange_flag_c_or_clock <= 1'b0;
      overrange_flag_d_or_clock <= 1'b0;
      synth_ref_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      overrange_flag_a <= next_pins[0];
      overrange_flag_b <= next_pins[1];
      overrange_flag_c_or_clock <= next_pins[2];
      overrange_flag_d_or_clock <= next_pins[3];
      synth_ref_out <= next_pins[4];
      irq <= next_pins[5];
    end
  end

  // Event edges for the sticky status bits
  logic [3:0] flag_prev;
  logic pd_prev;
  logic [ORC_IRQ_W-1:0] irq_events;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_prev <= 4'h0;
      pd_prev <= 1'b0;
    end else begin
      flag_prev <= flag_v;
      pd_prev <= pd_s;
    end
  end
  assign irq_events = {pd_s && !pd_prev, flag_v & ~flag_prev};

  // Status word: live view of flags, clock selection and synced pins
  always_comb begin
    status_word = 32'h00000000;
    status_word[3:0] = flag_v;
    status_word[4] = c_clk_on;
    status_word[5] = d_clk_on;
    status_word[6] = pd_s;
    status_word[7] = synth_en_s;
    status_word[9:8] = eff_sel;
  end

  // AHB-Lite: address phase captured, write applied in the data phase.
  // Reads are looked up at the address phase so data leaves a flop
  // with no wait state; the slave therefore never stretches a transfer.
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_take;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [31:0] next_config;
  logic [ORC_IRQ_W-1:0] next_irq_status;
  logic [ORC_IRQ_W-1:0] next_irq_enable;
  logic [ORC_IRQ_W-1:0] clr_mask;

  always_comb begin
    addr_take = hsel && hready && htrans[1];
    next_wr_pend = addr_take && hwrite;
    next_wr_addr = addr_take ? haddr[7:0] : wr_addr;
    next_hrdata = hrdata;
    if (addr_take && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        ORC_CONFIG_OFS: next_hrdata = config_reg;
        ORC_STATUS_OFS: next_hrdata = status_word;
        ORC_IRQ_STATUS_OFS: next_hrdata = {27'h0000000, irq_status};
        ORC_IRQ_ENABLE_OFS: next_hrdata = {27'h0000000, irq_enable};
        default: next_hrdata = 32'h00000000;
      endcase
    end
    next_config = config_reg;
    next_irq_enable = irq_enable;
    clr_mask = '0;
    if (wr_pend) begin
      case ({wr_addr[7:2], 2'b00})
        ORC_CONFIG_OFS: next_config = hwdata;
        ORC_IRQ_CLEAR_OFS: clr_mask = hwdata[ORC_IRQ_W-1:0];
        ORC_IRQ_ENABLE_OFS: next_irq_enable = hwdata[ORC_IRQ_W-1:0];
        default: next_config = config_reg;
      endcase
    end
    // A new event in the clearing cycle survives the clear
    next_irq_status = (irq_status & ~clr_mask) | irq_events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      config_reg <= ORC_CONFIG_RST;
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      config_reg <= next_config;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  // Checks on the pins
  b_unused_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (NUM_CHANNELS < 2) |-> !overrange_flag_b) else $error("B flag active in single build");
  c_no_detect_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (NUM_CHANNELS < 4 && !$past(c_clk_on)) |-> !overrange_flag_c_or_clock)
    else $error("C over-range in reduced build");
  c_clock_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!synth_en_s || eff_sel == ORC_SEL_FLAG) |=> overrange_flag_c_or_clock == $past(flag_v[2]))
    else $error("C clock without enable");
  c_flag_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !c_clk_on |=> overrange_flag_c_or_clock == $past(flag_v[2]))
    else $error("C pin not showing flag");
  ref_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (c_clk_on && eff_sel == ORC_SEL_REF) [*2] |=>
      overrange_flag_c_or_clock != $past(overrange_flag_c_or_clock))
    else $error("reference copy not toggling");
  // Starts just before the quarter rate changes level, so the level change and the following half period are seen
  div4_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (c_clk_on && eff_sel == ORC_SEL_DIV4 && ref_clk && ref_div2) ##1
      (c_clk_on && eff_sel == ORC_SEL_DIV4) [*4] |=>
      $stable(overrange_flag_c_or_clock) && overrange_flag_c_or_clock ==
      $past(overrange_flag_c_or_clock, 3) && overrange_flag_c_or_clock !=
      $past(overrange_flag_c_or_clock, 4))
    else $error("divide-by-4 period wrong");
  boot_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clock_out_config != 2'b00 && synth_enable && !powerdown_input
      && !config_reg[ORC_OVR_EN_BIT] && !config_reg[ORC_CLK_DIS_BIT]) [*3] |-> c_clk_on)
    else $error("pin-selected clock missing");
  d_needs_c_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !c_clk_on |=> overrange_flag_d_or_clock == $past(flag_v[3]))
    else $error("D clock without C clock");
  pd_stops_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_s |=> !synth_ref_out && overrange_flag_c_or_clock == $past(flag_v[2])
      && overrange_flag_d_or_clock == $past(flag_v[3]))
    else $error("clocks running in power-down");
  pin_a_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> overrange_flag_a == $past(flag_v[0])) else $error("A pin not registered flag");
  // Set must win: a rise in the clearing cycle is still recorded
  sticky_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_events[0] |=> irq_status[0]) else $error("flag rise not recorded");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(irq_status & irq_enable)) |=> irq) else $error("interrupt not raised");
endmodule

// file: dv/orc_sink_model.sv
// Far-side receiving logic: counts rising edges and last high length of each pin.
// Assumes the pins are sampled on the block's own clock, as system logic would.
`timescale 1ns/1ps
module orc_sink_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins: a, b, c, d, reference
  input wire logic [4:0] pins,
  // Measurements
  output logic [15:0] rises [5],
  output logic [15:0] hi_len [5]
);
  logic [4:0] last;
  logic [15:0] run [5];
  // Sampled once a cycle, so a glitch shorter than a cycle would go unseen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= '0;
      rises <= '{default: '0};
      hi_len <= '{default: '0};
      run <= '{default: '0};
    end else begin
      last <= pins;
      for (int i = 0; i < 5; i++) begin
        run[i] <= pins[i] ? run[i] + 16'h0001 : 16'h0000;
        if (pins[i] && !last[i]) begin
          rises[i] <= rises[i] + 16'h0001;
        end
        if (!pins[i] && last[i]) begin
          hi_len[i] <= run[i];
        end
      end
    end
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the over-range and clock-out select block.
// Assumes one AHB-Lite master (this bench) and the far-side model on the pins.
`timescale 1ns/1ps
module tb_top;
  import orc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, rd_dp, synth_enable, powerdown_input;
  logic [31:0] haddr, hwdata, rnd;
  logic [1:0] htrans, clock_out_config;
  logic [2:0] hsize;
  logic signed [11:0] sample_a, sample_b, sample_c, sample_d;
  wire logic hready, hresp, irq, fa, fb, fc, fd, ref_out, b1, c1;
  wire logic [31:0] hrdata;
  logic [15:0] rises [5];
  logic [15:0] hi_len [5];
  logic [15:0] base [5];
  logic [31:0] exp_q [$];
  int err_count, comparisons;

  orc_top #(.NUM_CHANNELS(4), .DATA_W(12)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sample_a(sample_a),
    .sample_b(sample_b), .sample_c(sample_c), .sample_d(sample_d),
    .clock_out_config(clock_out_config), .synth_enable(synth_enable),
    .powerdown_input(powerdown_input), .overrange_flag_a(fa), .overrange_flag_b(fb),
    .overrange_flag_c_or_clock(fc), .overrange_flag_d_or_clock(fd), .synth_ref_out(ref_out),
    .irq(irq));
  // Single-channel build shares the bus writes; its read side is left open
  orc_top #(.NUM_CHANNELS(1), .DATA_W(12)) uut_single (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(), .hresp(), .hrdata(), .sample_a(sample_a),
    .sample_b(sample_b), .sample_c(sample_c), .sample_d(sample_d),
    .clock_out_config(clock_out_config), .synth_enable(synth_enable),
    .powerdown_input(powerdown_input), .overrange_flag_a(), .overrange_flag_b(b1),
    .overrange_flag_c_or_clock(c1), .overrange_flag_d_or_clock(), .synth_ref_out(), .irq());
  orc_sink_model sink (.hclk(hclk), .hresetn(hresetn), .pins({ref_out, fd, fc, fb, fa}),
    .rises(rises), .hi_len(hi_len));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One AHB-Lite single transfer; the address phase is held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    htrans <= ORC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h00000000;
    rd_dp <= !wr;
    if (!wr) exp_q.push_back(d);
    do @(posedge hclk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Edge counts over 64 cycles are exact for any clock period dividing 64
  task automatic window;
    base = rises;
    wait_cyc(64);
  endtask

  function automatic logic [31:0] dlt(input int i);
    return {16'h0000, rises[i] - base[i]};
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random sample within the threshold band of +-100, both ends included
  function automatic logic [11:0] rand_s(input logic [7:0] x);
    int v;
    v = int'(x) % 201 - 100;
    return v[11:0];
  endfunction

  // Read data monitor: the oldest note is matched against the data phase
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
    end
  end

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    end_of_test;
  end

  initial begin
    {hresetn, hsel, hwrite, rd_dp, powerdown_input} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    {sample_a, sample_b, sample_c, sample_d} = '0;
    clock_out_config = 2'b01;
    synth_enable = 1'b1;
    rnd = 32'h000057BB;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ORC_CONFIG_OFS, ORC_CONFIG_RST);
    bus(1'b0, ORC_IRQ_ENABLE_OFS, 32'h00000000);
    bus(1'b0, 8'h40, 32'h00000000);
    check({31'd0, hresp}, 32'd0);
    // Pin-selected reference copy, no register setup
    window;
    check(dlt(2), 32'd32);
    check(dlt(4), 32'd32);
    for (int k = 1; k < 4; k++) begin
      clock_out_config <= k[1:0];
      wait_cyc(8);
      window;
      check(dlt(2), 32'd64 >> k);
      check(dlt(3), 32'd0);
    end
    clock_out_config <= 2'b00;
    bus(1'b1, ORC_CONFIG_OFS, 32'h00005064);
    wait_cyc(6);
    base = rises;
    // Sub-threshold random traffic, then a sample equal to the threshold
    repeat (30) begin
      rnd = lfsr(rnd);
      sample_a <= rand_s(rnd[7:0]);
      sample_b <= rand_s(rnd[15:8]);
      sample_c <= rand_s(rnd[23:16]);
      sample_d <= rand_s(rnd[31:24]);
      @(posedge hclk);
    end
    {sample_a, sample_b, sample_c, sample_d} <= {12'sd100, 36'd0};
    @(posedge hclk);
    sample_a <= '0;
    wait_cyc(4);
    for (int i = 0; i < 4; i++) check(dlt(i), 32'd0);
    // One over sample on a, b (negative) and c
    {sample_a, sample_b, sample_c} <= {12'sd101, -12'sd101, 12'sd101};
    @(posedge hclk);
    {sample_a, sample_b, sample_c} <= '0;
    for (int j = 0; j < 8; j++) begin
      @(posedge hclk);
      check({30'd0, b1, c1}, 32'd0);
    end
    wait_cyc(8);
    for (int i = 0; i < 3; i++) begin
      check(dlt(i), 32'd1);
      check({31'd0, hi_len[i] inside {16'd5, 16'd6}}, 32'd1);
    end
    // Sticky events, masking and write-one clear
    bus(1'b0, ORC_IRQ_STATUS_OFS, 32'h00000007);
    bus(1'b1, ORC_IRQ_ENABLE_OFS, 32'h00000001);
    wait_cyc(2);
    check({31'd0, irq}, 32'd1);
    bus(1'b1, ORC_IRQ_ENABLE_OFS, 32'h00000000);
    wait_cyc(2);
    check({31'd0, irq}, 32'd0);
    bus(1'b1, ORC_IRQ_CLEAR_OFS, 32'h0000001F);
    bus(1'b0, ORC_IRQ_STATUS_OFS, 32'h00000000);
    bus(1'b0, ORC_IRQ_CLEAR_OFS, 32'h00000000);
    // Register override to quarter reference, with the d pin clock enabled
    bus(1'b1, ORC_CONFIG_OFS, 32'h01705064);
    wait_cyc(4);
    window;
    check(dlt(2), 32'd8);
    check(dlt(3), 32'd8);
    bus(1'b0, ORC_STATUS_OFS, 32'h000003B0);
    bus(1'b1, ORC_CONFIG_OFS, 32'h01F05064);
    wait_cyc(4);
    window;
    check(dlt(2), 32'd0);
    check(dlt(3), 32'd0);
    bus(1'b1, ORC_CONFIG_OFS, 32'h01705064);
    synth_enable <= 1'b0;
    wait_cyc(6);
    window;
    check(dlt(2), 32'd0);
    synth_enable <= 1'b1;
    powerdown_input <= 1'b1;
    wait_cyc(6);
    window;
    for (int i = 2; i < 5; i++) check(dlt(i), 32'd0);
    bus(1'b0, ORC_IRQ_STATUS_OFS, 32'h00000010);
    bus(1'b0, ORC_STATUS_OFS, 32'h000003C0);
    powerdown_input <= 1'b0;
    wait_cyc(6);
    window;
    check(dlt(2), 32'd8);
    end_of_test;
  end
endmodule
